// ===== common/char_disp_pkg.sv
// shared constants for the serial character display driver
package char_disp_pkg;

   // ------------------------------------------------------------
   // clock and link timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ      = 125000000;
   localparam int unsigned BAUD_RATE   = 115200;
   localparam int unsigned BIT_CYCLES  = CLK_HZ / BAUD_RATE;
   localparam int unsigned HALF_CYCLES = BIT_CYCLES / 2;
   localparam logic [10:0] BIT_CNT_MAX = 11'(BIT_CYCLES - 1);
   localparam logic [10:0] HALF_CNT    = 11'(HALF_CYCLES - 1);

   // ------------------------------------------------------------
   // buffer and display layout
   // ------------------------------------------------------------
   localparam int unsigned BUF_DEPTH   = 16;
   localparam logic [3:0]  LAST_POS    = 4'hf;
   localparam logic [6:0]  BACKSPACE   = 7'h08;
   localparam logic [6:0]  BLANK_CHAR  = 7'h20;
   localparam logic [6:0]  CURSOR_CHAR = 7'h5f;
   localparam logic [3:0]  RST_POS     = 4'h0;
   localparam logic [22:0] BLINK_MAX   = 23'h7fffff;
   localparam logic [3:0]  STROBE_LEN  = 4'h8;
   localparam logic [3:0]  REFRESH_LEN = 4'hf;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } rx_state_e;

endpackage

// ===== core/char_disp_uart.sv
// serial receiver driving four four-character alphanumeric displays
// Summary of operation
// - serial link runs at 115200 baud; bits sampled at that rate.
// - received characters held in a sixteen-entry seven-bit-wide buffer.
// - buffer copied to all four modules continuously, also during reception.
// - new character when full shifts everything left, new one goes last.
// - blinking cursor shown where the next character will be written.
// - backspace code moves the input position back by one, not below the first; when full it only clears the full mark.
`timescale 1ns/1ns
module char_disp_uart
   import char_disp_pkg::*;
(
   // clock, reset and enable
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   input  wire logic       clkEn,
   // serial link
   input  wire logic       serialRx,
   output logic            serialTx,
   // display bus
   output logic [6:0]      charCode,
   output logic [1:0]      digitSelect,
   output logic [3:0]      moduleWriteStrobe
);

   // ------------------------------------------------------------
   // receiver
   // ------------------------------------------------------------
   rx_state_e   rxState_ff;
   logic [10:0] bitCnt_ff;
   logic [2:0]  bitIdx_ff;
   logic [7:0]  shiftReg_ff;
   logic        rxValid_ff;
   logic        rxPrev_ff;

   // input taken as synchronous; kept one flop for edge detection
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rxPrev_ff <= 1'b1;
      end else if (clkEn) begin
         rxPrev_ff <= serialRx;
      end
   end

   // 8n1 frame receiver, mid-bit sampling
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rxState_ff  <= RX_IDLE;
         bitCnt_ff   <= 11'h000;
         bitIdx_ff   <= 3'h0;
         shiftReg_ff <= 8'h00;
         rxValid_ff  <= 1'b0;
      end else if (clkEn) begin
         rxValid_ff <= 1'b0;
         case (rxState_ff)
            RX_IDLE: begin
               bitCnt_ff <= 11'h000;
               if (rxPrev_ff && !serialRx) begin
                  rxState_ff <= RX_START;
               end
            end
            RX_START: begin
               // recheck at half bit to reject glitches
               if (bitCnt_ff == HALF_CNT) begin
                  bitCnt_ff <= 11'h000;
                  bitIdx_ff <= 3'h0;
                  rxState_ff <= serialRx ? RX_IDLE : RX_DATA;
               end else begin
                  bitCnt_ff <= bitCnt_ff + 11'h001;
               end
            end
            RX_DATA: begin
               if (bitCnt_ff == BIT_CNT_MAX) begin
                  bitCnt_ff   <= 11'h000;
                  shiftReg_ff <= {serialRx, shiftReg_ff[7:1]};
                  bitIdx_ff   <= bitIdx_ff + 3'h1;
                  if (bitIdx_ff == 3'h7) begin
                     rxState_ff <= RX_STOP;
                  end
               end else begin
                  bitCnt_ff <= bitCnt_ff + 11'h001;
               end
            end
            RX_STOP: begin
               if (bitCnt_ff == BIT_CNT_MAX) begin
                  bitCnt_ff  <= 11'h000;
                  rxState_ff <= RX_IDLE;
                  // framing error drops the character
                  rxValid_ff <= serialRx;
               end else begin
                  bitCnt_ff <= bitCnt_ff + 11'h001;
               end
            end
            default: rxState_ff <= RX_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // character buffer and input position
   // ------------------------------------------------------------
   logic [6:0] charBuf_ff [BUF_DEPTH];
   logic [3:0] wrPos_ff;
   logic       full_ff;
   logic       isBackspace;
   logic       isPrintable;

   assign isBackspace = rxValid_ff && shiftReg_ff[6:0] == BACKSPACE
                        && !shiftReg_ff[7];
   // only printable codes are stored; other controls ignored
   assign isPrintable = rxValid_ff && !shiftReg_ff[7]
                        && shiftReg_ff[6:5] != 2'b00
                        && shiftReg_ff[6:0] != 7'h7f;

   // write or scroll per entry
   for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_buf
      // last entry names itself so the index never leaves the array
      localparam int NXT = (i == BUF_DEPTH - 1) ? i : i + 1;
      always_ff @(posedge clk_sys or negedge nrst) begin
         if (!nrst) begin
            charBuf_ff[i] <= BLANK_CHAR;
         end else if (clkEn && isPrintable) begin
            if (full_ff) begin
               // shift left, oldest entry drops out
               if (i == BUF_DEPTH - 1) begin
                  charBuf_ff[i] <= shiftReg_ff[6:0];
               end else begin
                  charBuf_ff[i] <= charBuf_ff[NXT];
               end
            end else if (wrPos_ff == 4'(i)) begin
               charBuf_ff[i] <= shiftReg_ff[6:0];
            end
         end
      end
   end

   // position steps forward, stops at last entry once full
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wrPos_ff <= RST_POS;
         full_ff  <= 1'b0;
      end else if (clkEn) begin
         if (isBackspace) begin
            full_ff <= 1'b0;
            if (!full_ff && wrPos_ff != RST_POS) begin
               wrPos_ff <= wrPos_ff - 4'h1;
            end
         end else if (isPrintable && !full_ff) begin
            if (wrPos_ff == LAST_POS) begin
               full_ff <= 1'b1;
            end else begin
               wrPos_ff <= wrPos_ff + 4'h1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // cursor blink
   // ------------------------------------------------------------
   logic [22:0] blinkCnt_ff;
   logic        blinkOn_ff;

   // roughly 15 hz toggle so the cursor is visible
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         blinkCnt_ff <= 23'h000000;
         blinkOn_ff  <= 1'b0;
      end else if (clkEn) begin
         blinkCnt_ff <= blinkCnt_ff + 23'h000001;
         if (blinkCnt_ff == BLINK_MAX) begin
            blinkOn_ff <= !blinkOn_ff;
         end
      end
   end

   // ------------------------------------------------------------
   // display refresh
   // ------------------------------------------------------------
   logic [3:0] scanPos_ff;
   logic [3:0] phase_ff;
   logic [6:0] scanChar;
   logic [3:0] cursorPos;

   // when full, the next write lands in the last position
   assign cursorPos = full_ff ? LAST_POS : wrPos_ff;
   // cursor overrides the entry at the input position
   assign scanChar = (blinkOn_ff && scanPos_ff == cursorPos)
                     ? CURSOR_CHAR : charBuf_ff[scanPos_ff];

   // free-running scan over all sixteen positions
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         scanPos_ff <= 4'h0;
         phase_ff   <= 4'h0;
      end else if (clkEn) begin
         if (phase_ff == REFRESH_LEN) begin
            phase_ff   <= 4'h0;
            scanPos_ff <= scanPos_ff + 4'h1;
         end else begin
            phase_ff <= phase_ff + 4'h1;
         end
      end
   end

   // data and address set up before the strobe, held after it
   // leftmost character sits at digit 3 of module 0
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         charCode          <= BLANK_CHAR;
         digitSelect       <= 2'h0;
         moduleWriteStrobe <= 4'h0;
      end else if (clkEn) begin
         if (phase_ff == 4'h0) begin
            charCode    <= scanChar;
            digitSelect <= ~scanPos_ff[1:0];
         end
         for (int m = 0; m < 4; m++) begin
            moduleWriteStrobe[m] <= phase_ff >= 4'h2
               && phase_ff < STROBE_LEN
               && scanPos_ff[3:2] == 2'(m);
         end
      end
   end

   // transmit line idles high; no transmit data defined
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         serialTx <= 1'b1;
      end else if (clkEn) begin
         serialTx <= 1'b1;
      end
   end

endmodule

// ===== verif/char_disp_uart_asserts.sv
// port-level checks for the character display driver
`timescale 1ns/1ns
module char_disp_uart_asserts
   import char_disp_pkg::*;
(
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       nrst,
   input wire logic       clkEn,
   // serial and display pins
   input wire logic       serialTx,
   input wire logic [6:0] charCode,
   input wire logic [1:0] digitSelect,
   input wire logic [3:0] moduleWriteStrobe
);
   wire logic stb = |moduleWriteStrobe;
   default clocking cb @(posedge clk_sys); endclocking
   // slot timing counts enabled cycles only, so a freeze aborts attempts
   default disable iff (!nrst || !clkEn);
   // start of a module write, then six cycles high and a gap
   sequence s_rise;
      $rose(stb);
   endsequence
   sequence s_pulse;
      stb [*6] ##1 !stb;
   endsequence
   a_tx_idle: assert property (serialTx) else $error("tx not idle");
   a_one_module: assert property ($onehot0(moduleWriteStrobe))
      else $error("two strobes");
   a_pulse_len: assert property (s_rise |-> s_pulse)
      else $error("strobe width");
   a_slot_gap: assert property (s_rise |-> ##16 $rose(stb))
      else $error("slot period");
   a_digit_step: assert property (s_rise |-> ##16
      digitSelect == $past(digitSelect, 16) - 2'h1) else $error("digit order");
   a_module_step: assert property ($rose(stb) && digitSelect == 2'h0
      |-> ##16 moduleWriteStrobe == {$past(moduleWriteStrobe[2:0], 16),
      $past(moduleWriteStrobe[3], 16)}) else $error("module order");
   a_bus_steady: assert property (stb |-> $stable(charCode)
      && $stable(digitSelect)) else $error("bus moved under strobe");
   a_code_legal: assert property (stb |-> charCode >= BLANK_CHAR
      && charCode != 7'h7f) else $error("unprintable code shown");
   // a low enable must hold every display pin where it stands
   a_hold_frozen: assert property (disable iff (!nrst) !clkEn |=>
      $stable(charCode) && $stable(digitSelect)
      && $stable(moduleWriteStrobe)) else $error("output moved while frozen");
endmodule
bind char_disp_uart char_disp_uart_asserts i_chk (.clk_sys(clk_sys),
   .nrst(nrst), .clkEn(clkEn), .serialTx(serialTx), .charCode(charCode),
   .digitSelect(digitSelect), .moduleWriteStrobe(moduleWriteStrobe));

// ===== verif/host_serial_model.sv
// host serial port and display module capture model
`timescale 1ns/1ns
module host_serial_model
   import char_disp_pkg::*;
(
   // clock
   input  wire logic       clk_sys,
   // serial link
   output logic            serialRx,
   // display bus
   input  wire logic [6:0] charCode,
   input  wire logic [1:0] digitSelect,
   input  wire logic [3:0] moduleWriteStrobe
);
   logic [6:0] shown [16];
   initial serialRx = 1'b1;
   // one 8n1 frame lsb first; line idles high between frames
   task automatic send_char(input logic [7:0] c);
      logic [9:0] f;
      f = {1'b1, c, 1'b0};
      for (int b = 0; b < 10; b++) begin
         @(negedge clk_sys) serialRx = f[b];
         repeat (BIT_CYCLES - 1) @(negedge clk_sys);
      end
   endtask
   // display modules latch the code while their strobe is up
   always @(posedge clk_sys) begin
      for (int m = 0; m < 4; m++) begin
         if (moduleWriteStrobe[m] === 1'b1) begin
            shown[4 * m + 3 - digitSelect] <= charCode;
         end
      end
   end
endmodule

// ===== verif/char_disp_uart_bench.sv
// self-checking bench for the serial character display driver
`timescale 1ns/1ns
module char_disp_uart_bench
   import char_disp_pkg::*;
;
   logic       clk_sys, nrst, clkEn, serialRx, serialTx;
   logic [6:0] charCode;
   logic [1:0] digitSelect;
   logic [3:0] moduleWriteStrobe;
   logic [6:0] exp [16];
   logic [3:0] pos;
   logic       full;
   logic [7:0] c;
   int         error_cnt, compares, seed;
   // clock; watchdog allows well over twenty frames
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   initial begin
      #3000000;
      error_cnt++;
      end_of_test();
   end
   char_disp_uart i_dut (.clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn),
      .serialRx(serialRx), .serialTx(serialTx), .charCode(charCode),
      .digitSelect(digitSelect), .moduleWriteStrobe(moduleWriteStrobe));
   host_serial_model i_host (.clk_sys(clk_sys), .serialRx(serialRx),
      .charCode(charCode), .digitSelect(digitSelect),
      .moduleWriteStrobe(moduleWriteStrobe));
   task automatic chk(input logic [7:0] act, input logic [7:0] want);
      compares++;
      if (act !== want) begin
         error_cnt++;
         $display("MISMATCH %0t got %h want %h", $time, act, want);
      end
   endtask
   // reference buffer: backspace when full only clears the full mark
   function automatic void apply(input logic [7:0] k);
      if (k == {1'b0, BACKSPACE}) begin
         if (full) full = 1'b0;
         else if (pos != RST_POS) pos = pos - 4'h1;
      end else if (k >= 8'h20 && k < 8'h7f) begin
         if (full) begin
            for (int i = 0; i < 15; i++) exp[i] = exp[i + 1];
         end
         exp[pos] = k[6:0];
         if (pos == LAST_POS) full = 1'b1;
         else pos = pos + 4'h1;
      end
   endfunction
   task automatic end_of_test();
      $display("error_cnt %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // clkEn drops once between frames, while the line is idle
   initial begin
      seed = 32'h1bfcf95b;
      error_cnt = 0;
      compares = 0;
      nrst = 1'b0;
      clkEn = 1'b1;
      full = 1'b0;
      pos = RST_POS;
      foreach (exp[i]) exp[i] = BLANK_CHAR;
      repeat (8) @(negedge clk_sys);
      chk({1'b0, charCode}, {1'b0, BLANK_CHAR});
      chk({6'h0, digitSelect}, 8'h00);
      chk({4'h0, moduleWriteStrobe}, 8'h00);
      chk({7'h0, serialTx}, 8'h01);
      nrst = 1'b1;
      // refused code, 17 to scroll, backspace when full, then one step back
      for (int n = 0; n < 21; n++) begin
         c = 8'h20 + 8'($unsigned($random(seed)) % 95);
         if (n == 0) c = 8'h07;
         if (n == 18 || n == 19) c = {1'b0, BACKSPACE};
         i_host.send_char(c);
         apply(c);
         if (n == 5) begin
            clkEn = 1'b0;
            repeat (16 + ($unsigned($random(seed)) % 48)) @(negedge clk_sys);
            clkEn = 1'b1;
         end
      end
      repeat (600) @(negedge clk_sys);
      foreach (exp[i]) chk({1'b0, i_host.shown[i]}, {1'b0, exp[i]});
      end_of_test();
   end
endmodule
